/* pkg/spims_pkg.sv */
// Operation
// - any reset sets the clock gate bit
// - cleared gate stops the block clock
// - master starts; shift registers swap bytes
// - master drives serial clock, slave receives
// - slave responds only while select low
// - written byte waits, loads at start
// - full received byte copied to receive buffer
// - master: clock out, drive mosi, sample miso
// - slave: pin clocks, drive miso, sample mosi
// - prescale divide one to eight
// - rate divide two to 256
// - disabled: release all four pins
// - single-wire master: mosi shared, oe sets direction
// - single-wire slave: mosi released
// - single-wire slave: miso shared, oe sets direction
// - single-wire master: miso released
// - master without fault detect: select released
// - master fault detect: select input or output
// - inactive in every stop mode
// - deep stop: wake in reset state
// - light stop: hold state, resume or reset
// - five eight-bit software registers
// - bit order msb or lsb first
// - clock polarity sets idle level
// - disable aborts, empties, resets flags
// - phase selects the sampling edge
package spims_pkg;
   localparam int unsigned       BYTE_W       = 8;
   localparam int unsigned       BIT_CNT_W    = 4;
   localparam logic [3:0]        BITS_PER_XFR = 4'h8;
   localparam logic [7:0]        DATA_RST     = 8'h00;
   localparam logic [2:0]        PRESC_RST    = 3'h0;
   localparam logic [2:0]        RATE_RST     = 3'h0;
   localparam logic              GATE_RST     = 1'b1;
   localparam int unsigned       DIV_CNT_W    = 11;
   typedef enum logic [1:0] {
      SPIMS_IDLE  = 2'b00,
      SPIMS_LEAD  = 2'b01,
      SPIMS_SHIFT = 2'b10,
      SPIMS_DONE  = 2'b11
   } spims_state_t;
endpackage

/* hw/spims_core.sv */
`timescale 1ns/1ps
`default_nettype none
module spims_core (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic       i_stop_deep,
   input  wire logic       i_stop_light,
   input  wire logic       i_gate_wr,
   input  wire logic       i_gate_val,
   input  wire logic       i_enable,
   input  wire logic       i_master,
   input  wire logic       i_cpol,
   input  wire logic       i_cpha,
   input  wire logic       i_lsb_first,
   input  wire logic       i_single_wire,
   input  wire logic       i_shared_oe,
   input  wire logic       i_fault_en,
   input  wire logic       i_sel_oe,
   input  wire logic [2:0] i_prescale,
   input  wire logic [2:0] i_rate,
   input  wire logic       i_tx_wr,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_rx_rd,
   input  wire logic       i_sck_in,
   input  wire logic       i_mosi_in,
   input  wire logic       i_miso_in,
   input  wire logic       i_ss_n_in,
   output logic            o_gate,
   output logic [7:0]      o_rx_data,
   output logic            o_rx_full,
   output logic            o_tx_empty,
   output logic            o_mode_fault,
   output logic            o_busy,
   output logic            o_sck_out,
   output logic            o_sck_oe,
   output logic            o_mosi_out,
   output logic            o_mosi_oe,
   output logic            o_miso_out,
   output logic            o_miso_oe,
   output logic            o_ss_n_out,
   output logic            o_ss_oe
);
   // pin synchronisers: first stage read only by second
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   always_ff @(posedge i_mclk) begin
      pin_s1 <= {i_sck_in, i_mosi_in, i_miso_in, i_ss_n_in};
      pin_s2 <= pin_s1;
   end
   logic sck_s;
   logic mosi_s;
   logic miso_s;
   logic ss_n_s;
   logic sck_d;
   assign sck_s  = pin_s2[3];
   assign mosi_s = pin_s2[2];
   assign miso_s = pin_s2[1];
   assign ss_n_s = pin_s2[0];

   // clock gate register
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || i_stop_deep) begin
         o_gate <= spims_pkg::GATE_RST;
      end else if (i_gate_wr) begin
         o_gate <= i_gate_val;
      end
   end

   // block clock enable: gate off or light stop freezes the sequencer and buffers; deep stop clears them
   logic run;
   logic live;
   assign run  = o_gate && !i_stop_light && !i_stop_deep;
   assign live = i_enable && run;
   // deep stop acts as reset on the way out
   logic clr;
   assign clr = !i_rst_n || i_stop_deep;

   // bit-rate divider: half bit tick every presc*rate/2 bus clocks, but every 2048 at divide 8 by 256
   // restarts per transfer so the first half bit is full length
   function automatic logic [10:0] half_period(input logic [2:0] p, input logic [2:0] r);
      logic [10:0] full;
      full = 11'({8'h00, p} + 11'h001) << (11'({8'h00, r}) + 11'h001);
      return 11'(full >> 1);
   endfunction
   logic [10:0] div_cnt;
   logic        half_tick;
   logic        m_active;
   assign half_tick = (div_cnt == half_period(i_prescale, i_rate) - 11'h001);
   always_ff @(posedge i_mclk) begin
      if (clr || !live || !m_active) begin
         div_cnt <= '0;
      end else if (run) begin
         div_cnt <= half_tick ? 11'h000 : div_cnt + 11'h001;
      end
   end

   spims_pkg::spims_state_t state;
   logic [7:0] shreg;
   logic [7:0] txbuf;
   logic [3:0] edges;
   logic       tx_full;
   logic       sdi;
   logic       bidir_in;
   logic       full_in;
   assign m_active = i_master && (state != spims_pkg::SPIMS_IDLE);
   assign bidir_in = i_master ? mosi_s : miso_s;
   assign full_in  = i_master ? miso_s : mosi_s;
   assign sdi      = i_single_wire ? bidir_in : full_in;

   // slave edge detect on synchronised clock
   // limitation: sck must stay below about mclk/8
   logic sl_sel;
   logic sl_lead;
   logic sl_trail;
   logic s_mode_lead;
   assign sl_sel      = !i_master && !ss_n_s;
   assign sl_lead     = sl_sel && (sck_s != sck_d) && ((sck_s ^ i_cpol) == 1'b1);
   assign sl_trail    = sl_sel && (sck_s != sck_d) && ((sck_s ^ i_cpol) == 1'b0);
   assign s_mode_lead = i_cpha ? sl_trail : sl_lead;
   always_ff @(posedge i_mclk) begin
      sck_d <= sck_s;
   end

   logic start;
   assign start = live && i_master && state == spims_pkg::SPIMS_IDLE && tx_full;
   logic m_sample;
   assign m_sample = live && half_tick && (edges[0] == i_cpha);
   logic [7:0] shifted;
   assign shifted = i_lsb_first ? {sdi, shreg[7:1]} : {shreg[6:0], sdi};
   logic fault;
   assign fault = live && i_master && i_fault_en && !i_sel_oe && !ss_n_s;

   // transfer sequencer, master and slave
   always_ff @(posedge i_mclk) begin
      if (clr || (run && !i_enable)) begin
         state <= spims_pkg::SPIMS_IDLE;
         edges <= '0;
         shreg <= spims_pkg::DATA_RST;
      end else if (run) begin
         case (state)
            spims_pkg::SPIMS_IDLE: begin
               edges <= '0;
               if (start) begin
                  shreg <= txbuf;
                  state <= spims_pkg::SPIMS_SHIFT;
               end else if (!i_master && sl_sel) begin
                  if (tx_full) begin
                     shreg <= txbuf;
                  end
                  state <= spims_pkg::SPIMS_LEAD;
               end
            end
            spims_pkg::SPIMS_SHIFT: begin
               if (fault) begin
                  state <= spims_pkg::SPIMS_IDLE;
               end else if (half_tick) begin
                  edges <= edges + 4'h1;
                  if (m_sample) begin
                     shreg <= shifted;
                  end
                  if (edges == 4'hf) begin
                     state <= spims_pkg::SPIMS_DONE;
                  end
               end
            end
            spims_pkg::SPIMS_LEAD: begin
               if (ss_n_s) begin
                  state <= spims_pkg::SPIMS_IDLE;
               end else if (s_mode_lead) begin
                  shreg <= shifted;
                  edges <= edges + 4'h2;
                  if (edges == 4'he) begin
                     state <= spims_pkg::SPIMS_DONE;
                  end
               end
            end
            spims_pkg::SPIMS_DONE: begin
               edges <= '0;
               state <= (!i_master && sl_sel) ? spims_pkg::SPIMS_LEAD
                                              : spims_pkg::SPIMS_IDLE;
               if (!i_master && sl_sel && tx_full) begin
                  shreg <= txbuf;
               end
            end
            default: state <= spims_pkg::SPIMS_IDLE;
         endcase
      end
   end

   // serial clock level; idles at polarity outside a shift
   always_ff @(posedge i_mclk) begin
      if (clr || (run && !i_enable)) begin
         o_sck_out <= i_cpol;
      end else if (run) begin
         if (state != spims_pkg::SPIMS_SHIFT) begin
            o_sck_out <= i_cpol;
         end else if (!fault && half_tick) begin
            o_sck_out <= ~o_sck_out;
         end
      end
   end

   // transmit buffer; a write in the load cycle stays queued
   logic loading;
   assign loading = run && (start || (!i_master && sl_sel && tx_full &&
                    (state == spims_pkg::SPIMS_IDLE || state == spims_pkg::SPIMS_DONE)));
   always_ff @(posedge i_mclk) begin
      if (clr || (run && !i_enable)) begin
         txbuf <= spims_pkg::DATA_RST;
      end else if (run && i_tx_wr) begin
         txbuf <= i_tx_data;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (clr || (run && !i_enable)) begin
         tx_full <= 1'b0;
      end else if (run) begin
         if (i_tx_wr) begin
            tx_full <= 1'b1;
         end else if (loading) begin
            tx_full <= 1'b0;
         end
      end
   end

   // flag frozen with the rest while light-stopped or gated
   always_ff @(posedge i_mclk) begin
      o_tx_empty <= (clr || (run && !i_enable)) ? 1'b1 : !(tx_full || (run && i_tx_wr));
   end

   // receive buffer; completion wins over a same-cycle read
   // no overrun flag: an unread byte is overwritten
   always_ff @(posedge i_mclk) begin
      if (clr || (run && !i_enable)) begin
         o_rx_data <= spims_pkg::DATA_RST;
      end else if (run && state == spims_pkg::SPIMS_DONE) begin
         o_rx_data <= shreg;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (clr || (run && !i_enable)) begin
         o_rx_full <= 1'b0;
      end else if (run) begin
         if (state == spims_pkg::SPIMS_DONE) begin
            o_rx_full <= 1'b1;
         end else if (i_rx_rd) begin
            o_rx_full <= 1'b0;
         end
      end
   end

   // mode fault is sticky until disable
   // only seen while enabled, so it never meets the clear
   always_ff @(posedge i_mclk) begin
      if (clr || (run && !i_enable)) begin
         o_mode_fault <= 1'b0;
      end else if (run && fault) begin
         o_mode_fault <= 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      o_busy <= !clr && state != spims_pkg::SPIMS_IDLE;
   end

   // pin routing; stop or disable releases all pins
   logic en_pins;
   logic out_bit;
   assign en_pins = i_enable && run && i_rst_n;
   assign out_bit = i_lsb_first ? shreg[0] : shreg[7];

   always_ff @(posedge i_mclk) begin
      o_sck_oe <= en_pins && i_master;
   end

   // data levels follow the shifter even while released
   always_ff @(posedge i_mclk) begin
      o_mosi_out <= out_bit;
      o_miso_out <= out_bit;
   end

   always_ff @(posedge i_mclk) begin
      o_mosi_oe <= en_pins && i_master && (!i_single_wire || i_shared_oe);
   end

   always_ff @(posedge i_mclk) begin
      o_miso_oe <= en_pins && !i_master && sl_sel
                   && (!i_single_wire || i_shared_oe);
   end

   // select low for the whole busy span
   always_ff @(posedge i_mclk) begin
      o_ss_n_out <= !m_active;
   end

   always_ff @(posedge i_mclk) begin
      o_ss_oe <= en_pins && i_master && i_fault_en && i_sel_oe;
   end
endmodule
`default_nettype wire

/* test/spims_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module spims_sva (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_stop_deep,
   input wire logic i_stop_light,
   input wire logic i_enable,
   input wire logic i_master,
   input wire logic i_single_wire,
   input wire logic i_fault_en,
   input wire logic i_tx_wr,
   input wire logic o_gate,
   input wire logic o_tx_empty,
   input wire logic o_rx_full,
   input wire logic o_mode_fault,
   input wire logic o_sck_oe,
   input wire logic o_mosi_oe,
   input wire logic o_miso_oe,
   input wire logic o_ss_oe
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // two cycles of settled config, since every output is registered
   off_release_a: assert property ((!i_enable && o_gate) [*2]
      |-> !(o_sck_oe | o_mosi_oe | o_miso_oe | o_ss_oe)) else $error("pin driven while off");
   off_flags_a: assert property ((!i_enable && o_gate && !i_stop_light) [*2]
      |-> o_tx_empty && !o_rx_full) else $error("flags not cleared while off");
   master_sck_a: assert property ((i_enable && i_master && o_gate && !o_mode_fault
      && !i_stop_deep && !i_stop_light) [*2] |-> o_sck_oe)
      else $error("master not driving clock");
   slave_sck_a: assert property ((i_enable && !i_master && o_gate) [*2] |-> !o_sck_oe)
      else $error("slave driving clock");
   sw_miso_a: assert property ((i_enable && i_master && i_single_wire) [*2] |-> !o_miso_oe)
      else $error("miso driven in single wire master");
   sw_mosi_a: assert property ((i_enable && !i_master && i_single_wire) [*2] |-> !o_mosi_oe)
      else $error("mosi driven in single wire slave");
   no_fault_ss_a: assert property ((i_enable && i_master && !i_fault_en) [*2] |-> !o_ss_oe)
      else $error("select driven without fault detect");
   gate_rst_a: assert property (disable iff (1'b0) !i_rst_n |=> o_gate && o_tx_empty && !o_rx_full)
      else $error("reset values wrong");
   wr_load_a: assert property (i_enable && o_gate && i_tx_wr && o_tx_empty
      && !i_stop_light && !i_stop_deep |=> !o_tx_empty) else $error("write not buffered");
   cover property ($rose(o_rx_full));
   cover property ($rose(o_mode_fault));
   cover property (i_single_wire && o_mosi_oe);
endmodule
bind spims_core spims_sva u_sva (.*);
`default_nettype wire

/* test/spims_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module spims_peer (
   input  wire logic       i_sck,
   input  wire logic       i_mosi,
   input  wire logic       i_ss_n,
   input  wire logic       i_cpol,
   input  wire logic       i_cpha,
   input  wire logic       i_lsb,
   input  wire logic [7:0] i_tx,
   output logic            o_miso,
   output logic [7:0]      o_rx
);
   logic [7:0] t;
   logic       first;
   always @(negedge i_ss_n) begin
      t = i_tx;
      first = 1'b1;
   end
   // sample edge captures; the other edge shifts, skipped once when phase is 1
   always @(i_sck) begin
      if (!i_ss_n && ((i_sck != i_cpol) != i_cpha))
         o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
      else if (!i_ss_n && !(first && i_cpha))
         t = i_lsb ? t >> 1 : t << 1;
      first = 1'b0;
   end
   // released line flips so a stale bit never looks valid
   always @(i_ss_n or t) o_miso = i_ss_n ? ~o_miso : (i_lsb ? t[0] : t[7]);
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin fails++; \
   $display("FAIL %s exp %h got %h", n, e, s); end end
module tb;
   logic        i_mclk, i_rst_n, i_stop_deep, i_stop_light, i_gate_wr, i_gate_val, i_enable;
   logic        i_master, i_cpol, i_cpha, i_lsb_first, i_single_wire, i_shared_oe, i_fault_en;
   logic        i_sel_oe, i_tx_wr, i_rx_rd, ss_tb, p_miso, sck_q, busy_q;
   logic [2:0]  i_prescale, i_rate;
   logic [7:0]  i_tx_data, o_rx_data, p_tx, p_rx;
   logic        o_gate, o_rx_full, o_tx_empty, o_mode_fault, o_busy, o_sck_out, o_sck_oe;
   logic        o_mosi_out, o_mosi_oe, o_miso_out, o_miso_oe, o_ss_n_out, o_ss_oe;
   wire logic   i_sck_in, i_mosi_in, i_miso_in, i_ss_n_in;
   logic [31:0] exp_q[$];
   logic [31:0] e;
   int          fails, checks, tog, gap, hgap, seed;
   assign i_sck_in = o_sck_oe ? o_sck_out : i_cpol;
   assign i_mosi_in = o_mosi_oe ? o_mosi_out : ~o_mosi_out;
   assign i_miso_in = o_miso_oe ? o_miso_out : p_miso;
   assign i_ss_n_in = o_ss_oe ? o_ss_n_out : ss_tb;
   spims_core DUT (.*);
   spims_peer u_peer (.i_sck(i_sck_in), .i_mosi(i_mosi_in), .i_ss_n(i_ss_n_in), .i_cpol(i_cpol),
      .i_cpha(i_cpha), .i_lsb(i_lsb_first), .i_tx(p_tx), .o_miso(p_miso), .o_rx(p_rx));
   always #10 i_mclk = ~i_mclk;
   task automatic end_of_test;
      if (fails == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge i_mclk);
   endtask
   task automatic wr(input logic [7:0] d);
      i_tx_data = d;
      i_tx_wr = 1'b1;
      step(1);
      i_tx_wr = 1'b0;
   endtask
   // rate divide kept at 8 or more so the synced miso settles before sampling
   task automatic xfer(input logic [2:0] m);
      logic [7:0] d;
      d = 8'($random(seed));
      p_tx = 8'($random(seed));
      i_prescale = 3'($random(seed));
      i_rate = 3'h2 + {2'h0, 1'($random(seed))};
      {i_cpol, i_cpha, i_lsb_first} = m;
      step(4);
      exp_q.push_back({p_tx, d, (16'(i_prescale) + 16'h1) << i_rate});
      wr(d);
      for (int k = 0; k < 3000 && exp_q.size() != 0; k++) step(1);
      `CHK("xfer_done", 0, exp_q.size())
   endtask
   always @(negedge i_mclk) begin
      i_rx_rd <= 1'b0;
      gap = gap + 1;
      if (o_busy && !busy_q) tog = 0;
      if (o_sck_out != sck_q) begin
         tog++;
         hgap = gap;
         gap = 0;
      end
      {sck_q, busy_q} = {o_sck_out, o_busy};
      if (o_rx_full && !i_rx_rd) begin
         e = exp_q.pop_front();
         `CHK("rx_data", e[31:24], o_rx_data)
         `CHK("peer_rx", e[23:16], p_rx)
         `CHK("toggles", 16, tog)
         `CHK("half_period", e[15:0], 16'(hgap))
         i_rx_rd <= 1'b1;
      end
   end
   initial begin
      repeat (40000) @(posedge i_mclk);
      fails++;
      end_of_test();
   end
   initial begin
      {i_mclk, i_rst_n, i_stop_deep, i_stop_light, i_gate_wr, i_gate_val} = 6'h00;
      {i_cpol, i_cpha, i_lsb_first, i_single_wire, i_shared_oe, i_tx_wr, i_rx_rd} = 7'h00;
      {i_enable, i_master, i_fault_en, i_sel_oe, ss_tb} = 5'h1f;
      {i_prescale, i_rate, i_tx_data, p_tx} = 22'h0;
      seed = 20419;
      step(2);
      i_rst_n = 1'b1;
      step(1);
      `CHK("gate", 1'b1, o_gate)
      `CHK("tx_empty", 1'b1, o_tx_empty)
      `CHK("sck_idle", i_cpol, o_sck_out)
      for (int m = 0; m < 8; m++) xfer(3'(m));
      wr(8'h3c);
      step(3);
      wr(8'hc3);
      `CHK("tx_held", 1'b0, o_tx_empty)
      `CHK("busy", 1'b1, o_busy)
      i_enable = 1'b0;
      step(5);
      `CHK("abort", 3'h1, {o_busy, o_rx_full, o_tx_empty})
      `CHK("released", 1'b0, o_sck_oe | o_mosi_oe | o_ss_oe)
      {i_enable, i_gate_wr} = 2'b11;
      step(1);
      i_gate_wr = 1'b0;
      wr(8'h5a);
      step(5);
      `CHK("gated", 3'h1, {o_gate, o_busy, o_tx_empty})
      i_stop_deep = 1'b1;
      step(2);
      i_stop_deep = 1'b0;
      step(1);
      `CHK("wake", 1'b1, o_gate)
      {i_fault_en, i_single_wire, i_shared_oe} = 3'b011;
      step(5);
      `CHK("sw_master", 3'h4, {o_mosi_oe, o_miso_oe, o_ss_oe})
      i_shared_oe = 1'b0;
      step(5);
      `CHK("sw_input", 1'b0, o_mosi_oe)
      {i_master, i_shared_oe, ss_tb} = 3'b011;
      wr(8'ha5);
      ss_tb = 1'b0;
      step(5);
      `CHK("sw_slave", 4'h7, {o_mosi_oe, o_miso_oe, o_miso_out, o_tx_empty})
      {i_single_wire, ss_tb} = 2'b01;
      step(5);
      `CHK("deselect", 1'b0, o_miso_oe | o_sck_oe)
      {i_master, i_fault_en, i_sel_oe, ss_tb} = 4'b1100;
      step(5);
      `CHK("fault", 2'h2, {o_mode_fault, o_ss_oe})
      {i_stop_light, i_enable} = 2'b10;
      step(3);
      `CHK("light_hold", 2'h2, {o_mode_fault, o_sck_oe})
      i_stop_light = 1'b0;
      step(2);
      `CHK("light_exit", 1'b0, o_mode_fault)
      end_of_test();
   end
endmodule
`default_nettype wire
